//--- shared/ast_pkg.sv
// Constants and types for the converter serial timeout and sync block.
// Assumes a 32-bit AXI4-Lite register bus and a separate serial clock.
`default_nettype none
package ast_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PERIOD = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_RESULT = 8'h0C;
    localparam logic [7:0] ADDR_MODCNT = 8'h10;
    // Control field positions
    localparam int CTRL_SYNC_BIT = 0;
    localparam int CTRL_TWOS_BIT = 1;
    // Status field positions
    localparam int STAT_READY_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_ABORT_BIT = 2;
    localparam int STAT_TOCNT_LSB = 8;
    // Reset values and encodings
    localparam logic [15:0] PERIOD_RST = 16'h0100;
    localparam logic [15:0] PERIOD_ONE = 16'h0001;
    localparam logic [23:0] SIGN_FLIP = 24'h80_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Timing counts
    localparam int TIMEOUT_PERIODS_LOG2 = 2;
    localparam logic [4:0] INSTR_LAST = 5'h07;
    localparam logic [4:0] DATA_LAST = 5'h18;
    // Word types
    typedef logic [31:0] ast_word_t;
    typedef logic [23:0] ast_sample_t;
    // Settings that software writes
    typedef struct packed {
        logic twos;
        logic [15:0] period;
    } ast_ctrl_t;
    // Serial port sequencer states
    typedef enum logic [1:0] {
        LNK_IDLE = 2'b00,
        LNK_INSTR = 2'b01,
        LNK_READ = 2'b10
    } ast_lnk_state_t;
endpackage
`default_nettype wire

//--- hdl/ast_top.sv
// Conversion sequencer, serial read port and serial timeout recovery.
// Assumes the host drives link_sclk and serial_in, sampled on rising edges,
// and that raw_sample is produced on aclk by the modulator logic.
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ast_top
(
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire ast_pkg::ast_word_t wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output ast_pkg::ast_word_t rdata,
    output logic [1:0] rresp,
    // Modulator side
    input wire ast_pkg::ast_sample_t raw_sample,
    input wire logic sync_pulse_n,
    output logic result_ready_n,
    // Serial link
    input wire logic link_sclk,
    input wire logic serial_in,
    output logic serial_out_pin,
    output logic serial_out_oe
);
    import ast_pkg::*;

    // Byte-lane merge used by every writable register
    function automatic ast_word_t merge(input ast_word_t old,
                                        input ast_word_t nw,
                                        input logic [3:0] strb);
        ast_word_t res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                res[i*8 +: 8] = nw[i*8 +: 8];
        end
        return res;
    endfunction

    // Register state
    ast_ctrl_t ctrl_r;
    logic [15:0] mod_cnt_r;
    logic pend_r;
    logic ready_n_r;
    ast_sample_t hist1_r;
    ast_sample_t hist2_r;
    ast_sample_t dor_r;
    logic [17:0] to_cyc_r;
    logic abort_r;
    logic [7:0] to_count_r;
    // Synchronisers into aclk
    logic sy1_r, sy2_r, sy3_r;
    logic bs1_r, bs2_r;
    logic ac1_r, ac2_r, ac3_r;
    // AXI slave state
    logic aw_full_r, w_full_r, bvalid_r, rvalid_r;
    logic [7:0] aw_addr_r;
    ast_word_t w_data_r;
    logic [3:0] w_strb_r;
    logic [1:0] bresp_r, rresp_r;
    ast_word_t rdata_r;
    // Link domain state
    ast_lnk_state_t lnk_state_r;
    logic [4:0] bit_cnt_r;
    logic [7:0] instr_sr_r;
    ast_sample_t out_sr_r;
    ast_sample_t snap_r;
    logic sout_r, oe_r, busy_r, act_tgl_r;

    // Bus handshakes, gated by the enable so nothing is taken when frozen
    wire aw_take = awvalid & awready;
    wire w_take = wvalid & wready;
    wire do_write = aw_full_r & w_full_r & ~bvalid_r & ce;
    wire ar_take = arvalid & arready;
    assign awready = ce & ~aw_full_r & ~bvalid_r;
    assign wready = ce & ~w_full_r & ~bvalid_r;
    assign arready = ce & ~rvalid_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

    // Write decode
    wire wr_ctrl = do_write & (aw_addr_r == ADDR_CTRL);
    wire wr_period = do_write & (aw_addr_r == ADDR_PERIOD);
    wire wr_known = wr_ctrl | wr_period;
    ast_word_t ctrl_word;
    ast_word_t ctrl_merged;
    ast_word_t period_merged;
    assign ctrl_word = {30'h0, ctrl_r.twos, 1'b0};
    assign ctrl_merged = merge(ctrl_word, w_data_r, w_strb_r);
    assign period_merged = merge({16'h0, ctrl_r.period}, w_data_r, w_strb_r);
    wire cmd_sync = wr_ctrl & ctrl_merged[CTRL_SYNC_BIT];

    // Sync pin edge, seen two flops after the pin; an unaligned pulse may
    // land one clock apart on different parts
    wire pin_sync = sy3_r & ~sy2_r;
    wire clear_cnt = pin_sync | cmd_sync;
    wire mod_end = (mod_cnt_r == (ctrl_r.period - PERIOD_ONE));

    // Three-tap history filter over the newest sample and two older words
    logic [25:0] filt_sum;
    ast_sample_t filt_ob;
    ast_sample_t result_fmt;
    assign filt_sum = {2'b00, raw_sample} + {1'b0, hist1_r, 1'b0}
                    + {2'b00, hist2_r};
    assign filt_ob = filt_sum[25:2];
    // Offset binary mid-scale flips to zero in two's complement
    assign result_fmt = ctrl_r.twos ? (filt_ob ^ SIGN_FLIP) : filt_ob;

    // Timeout limit of four conversion periods in clock cycles
    wire [17:0] to_limit = {ctrl_r.period, {TIMEOUT_PERIODS_LOG2{1'b0}}};
    wire link_act = ac2_r ^ ac3_r;

    // Read mux
    ast_word_t status_word;
    ast_word_t rd_mux;
    logic rd_known;
    assign status_word = {16'h0, to_count_r, 5'h00, abort_r, bs2_r,
                          ~ready_n_r};
    always_comb
    begin
        rd_known = 1'b1;
        case (araddr)
            ADDR_CTRL: rd_mux = ctrl_word;
            ADDR_PERIOD: rd_mux = {16'h0, ctrl_r.period};
            ADDR_STATUS: rd_mux = status_word;
            ADDR_RESULT: rd_mux = {8'h00, dor_r};
            ADDR_MODCNT: rd_mux = {16'h0, mod_cnt_r};
            default:
            begin
                rd_mux = 32'h0000_0000;
                rd_known = 1'b0;
            end
        endcase
    end

    // Write address and data holding, either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end
        else if (ce)
        begin
            if (aw_take)
            begin
                aw_full_r <= 1'b1;
                aw_addr_r <= awaddr;
            end
            else if (do_write)
                aw_full_r <= 1'b0;
            if (w_take)
            begin
                w_full_r <= 1'b1;
                w_data_r <= wdata;
                w_strb_r <= wstrb;
            end
            else if (do_write)
                w_full_r <= 1'b0;
        end
    end

    // Write response and read answer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end
        else if (ce)
        begin
            if (do_write)
            begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bready)
                bvalid_r <= 1'b0;
            if (ar_take)
            begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_mux;
                rresp_r <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end
            else if (rready)
                rvalid_r <= 1'b0;
        end
    end

    // Control register; the sync bit is a command and is not stored
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r.twos <= 1'b0;
            ctrl_r.period <= PERIOD_RST;
        end
        else if (ce)
        begin
            if (wr_ctrl)
                ctrl_r.twos <= ctrl_merged[CTRL_TWOS_BIT];
            if (wr_period)
                ctrl_r.period <= period_merged[15:0];
        end
    end

    // Synchronisers for the sync pin, link busy and link activity
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {sy1_r, sy2_r, sy3_r} <= 3'h7;
            {bs1_r, bs2_r} <= 2'h0;
            {ac1_r, ac2_r, ac3_r} <= 3'h0;
        end
        else if (ce)
        begin
            {sy1_r, sy2_r, sy3_r} <= {sync_pulse_n, sy1_r, sy2_r};
            {bs1_r, bs2_r} <= {busy_r, bs1_r};
            {ac1_r, ac2_r, ac3_r} <= {act_tgl_r, ac1_r, ac2_r};
        end
    end

    // Modulator count and result update sequence
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mod_cnt_r <= 16'h0000;
            pend_r <= 1'b0;
            ready_n_r <= 1'b1;
            hist1_r <= SIGN_FLIP;
            hist2_r <= SIGN_FLIP;
            dor_r <= 24'h00_0000;
        end
        else if (ce)
        begin
            if (clear_cnt)
                mod_cnt_r <= 16'h0000;
            else if (mod_end)
                mod_cnt_r <= 16'h0000;
            else
                mod_cnt_r <= mod_cnt_r + PERIOD_ONE;
            if (mod_end && !clear_cnt)
            begin
                ready_n_r <= 1'b1;
                pend_r <= 1'b1;
            end
            else if (pend_r)
            begin
                // History words survive sync; only the count restarts
                pend_r <= 1'b0;
                dor_r <= result_fmt;
                hist2_r <= hist1_r;
                hist1_r <= raw_sample;
            end
            else
                ready_n_r <= 1'b0;
        end
    end
    assign result_ready_n = ready_n_r;

    // Stall timer; only the serial port is reset, registers stay
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            to_cyc_r <= 18'h0_0000;
            abort_r <= 1'b1;
            to_count_r <= 8'h00;
        end
        else if (ce)
        begin
            if (!bs2_r)
            begin
                to_cyc_r <= 18'h0_0000;
                abort_r <= 1'b0;
            end
            else if (link_act)
                to_cyc_r <= 18'h0_0000;
            else if (!abort_r && to_cyc_r > to_limit)
            begin
                abort_r <= 1'b1;
                to_count_r <= to_count_r + 8'h01;
            end
            else if (!abort_r)
                to_cyc_r <= to_cyc_r + 18'h0_0001;
        end
    end

    // Link side: instruction byte, then 24 result bits on a read.
    // The abort flop resets it without needing serial edges
    wire lnk_rst = abort_r;
    always_ff @(posedge link_sclk or posedge lnk_rst)
    begin
        if (lnk_rst)
        begin
            lnk_state_r <= LNK_IDLE;
            bit_cnt_r <= 5'h00;
            instr_sr_r <= 8'h00;
            out_sr_r <= 24'h00_0000;
            sout_r <= 1'b0;
            oe_r <= 1'b0;
            busy_r <= 1'b0;
            act_tgl_r <= 1'b0;
        end
        else
        begin
            act_tgl_r <= ~act_tgl_r;
            case (lnk_state_r)
                LNK_IDLE:
                begin
                    instr_sr_r <= {instr_sr_r[6:0], serial_in};
                    bit_cnt_r <= 5'h01;
                    busy_r <= 1'b1;
                    lnk_state_r <= LNK_INSTR;
                end
                LNK_INSTR:
                begin
                    instr_sr_r <= {instr_sr_r[6:0], serial_in};
                    if (bit_cnt_r == INSTR_LAST && instr_sr_r[6])
                    begin
                        lnk_state_r <= LNK_READ;
                        sout_r <= snap_r[23];
                        out_sr_r <= {snap_r[22:0], 1'b0};
                        oe_r <= 1'b1;
                        bit_cnt_r <= 5'h01;
                    end
                    else if (bit_cnt_r == INSTR_LAST)
                    begin
                        lnk_state_r <= LNK_IDLE;
                        busy_r <= 1'b0;
                    end
                    else
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                end
                LNK_READ:
                begin
                    if (bit_cnt_r == DATA_LAST)
                    begin
                        lnk_state_r <= LNK_IDLE;
                        oe_r <= 1'b0;
                        busy_r <= 1'b0;
                    end
                    else
                    begin
                        sout_r <= out_sr_r[23];
                        out_sr_r <= {out_sr_r[22:0], 1'b0};
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                    end
                end
                default:
                begin
                    lnk_state_r <= LNK_IDLE;
                    oe_r <= 1'b0;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    // Result snapshot for the link: it follows the result only while the
    // synchronised busy flag is low, so the word stands still from the
    // second aclk edge after the first serial edge until its bits are shifted out, and a stopped
    // serial clock can never leave an old or unknown word behind
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            snap_r <= 24'h00_0000;
        else if (ce && !bs2_r)
            snap_r <= dor_r;
    end
    assign serial_out_pin = sout_r;
    assign serial_out_oe = oe_r;
endmodule
`default_nettype wire

//--- sim/ast_top_sva.sv
// Checker for the converter block: bus handshakes, data-ready, serial pin.
// Assumes it is bound to ast_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module ast_top_sva
(
    // Clocks and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic link_sclk,
    // Bus handshakes
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire ast_pkg::ast_word_t rdata,
    // Converter and link
    input wire logic result_ready_n,
    input wire logic serial_out_oe
);
    import ast_pkg::*;
    // Write answer stands until taken
    property p_b_hold;
        @(posedge aclk) disable iff (!aresetn)
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    // Read answer stands until taken
    property p_r_hold;
        @(posedge aclk) disable iff (!aresetn)
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
    // Read answer one cycle after the address is taken
    property p_r_lat;
        @(posedge aclk) disable iff (!aresetn)
        arvalid && arready |=> rvalid;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read late");
    // No new write taken while an answer waits
    property p_w_busy;
        @(posedge aclk) disable iff (!aresetn)
        bvalid |-> !awready && !wready;
    endproperty
    a_w_busy: assert property (p_w_busy) else $error("write overlap");
    // No new read taken while an answer waits
    property p_ar_busy;
        @(posedge aclk) disable iff (!aresetn)
        rvalid |-> !arready;
    endproperty
    a_ar_busy: assert property (p_ar_busy) else $error("read overlap");
    // Data-ready high for exactly the two update cycles
    property p_rdy_pulse;
        @(posedge aclk) disable iff (!aresetn)
        $rose(result_ready_n) |=> result_ready_n ##1 !result_ready_n;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready");
    // Pin driven only from a serial clock edge on
    property p_oe_edge;
        @(posedge aclk) disable iff (!aresetn)
        $rose(serial_out_oe) |-> link_sclk;
    endproperty
    a_oe_edge: assert property (p_oe_edge) else $error("oe start");
    // Pin stays driven through all result bits
    property p_oe_len;
        @(posedge link_sclk) disable iff (!aresetn)
        $rose(serial_out_oe) |-> ##23 serial_out_oe;
    endproperty
    a_oe_len: assert property (p_oe_len) else $error("oe length");
endmodule
bind ast_top ast_top_sva u_ast_top_sva
(
    .aclk(aclk),
    .aresetn(aresetn),
    .link_sclk(link_sclk),
    .awready(awready),
    .wready(wready),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .result_ready_n(result_ready_n),
    .serial_out_oe(serial_out_oe)
);
`default_nettype wire

//--- sim/ast_host_model.sv
// Host serial port model: clocks the link in frames, reads result bits.
// Assumes the converter drives its pin only while its enable is high.
`timescale 1ns/1ps
`default_nettype none
module ast_host_model
(
    // Link to the converter
    output logic link_sclk,
    output logic serial_in,
    input wire logic serial_out_pin,
    input wire logic serial_out_oe,
    // Received word to the bench
    output logic [23:0] rx_word,
    output logic rx_stb
);
    logic last_bit = 1'b0;
    logic [23:0] sh = 24'h00_0000;
    // Released pin shows the inverse of its last level
    wire logic line = serial_out_oe ? serial_out_pin : ~last_bit;
    // Idle link: clock stands low
    initial
    begin
        link_sclk = 1'b0;
        serial_in = 1'b0;
        rx_word = 24'h00_0000;
        rx_stb = 1'b0;
    end
    // Frame of n edges, always opening with a fresh instruction byte
    task automatic frame(input logic [7:0] instr, input int n);
        #13;
        for (int i = 0; i < n; i++)
        begin
            serial_in = (i < 8) ? instr[7 - i] : ~serial_in;
            #80 link_sclk = 1'b1;
            #80 link_sclk = 1'b0;
            if (i >= 7 && i < 31)
            begin
                sh = {sh[22:0], line};
                last_bit = line;
            end
        end
        if (n == 32)
        begin
            rx_word = sh;
            rx_stb = 1'b1;
            #1 rx_stb = 1'b0;
        end
        serial_in = ~serial_in;
    endtask
endmodule
`default_nettype wire

//--- sim/ast_top_bench.sv
// Self-checking bench for ast_top: registers, conversions, sync, link.
// Assumes the host model makes the serial clock in frames.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, g) begin n_tests++; if ((g) !== (ex)) begin err_count++; \
    $display("wrong value %s exp %h got %h", nm, ex, g); end end
module ast_top_bench;
    import ast_pkg::*;
    localparam ast_word_t PER = 32'h0000_0010;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, sync_pulse_n = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [3:0] wstrb = 4'hf;
    ast_word_t wdata = 32'h0000_0000;
    ast_sample_t raw_sample = 24'h80_0000;
    logic awready, wready, bvalid, arready, rvalid, result_ready_n;
    logic [1:0] bresp, rresp;
    ast_word_t rdata;
    logic link_sclk, serial_in, serial_out_pin, serial_out_oe, rx_stb;
    logic [23:0] rx_word;
    logic [65:0] q[$];
    logic [65:0] e;
    logic [31:0] seed = 32'h0000_488c;
    logic [25:0] s;
    ast_sample_t x;
    int err_count = 0, n_tests = 0, n;
    always #25 aclk = ~aclk;
    ast_top u_ast_top
    (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .raw_sample(raw_sample), .sync_pulse_n(sync_pulse_n),
        .result_ready_n(result_ready_n), .link_sclk(link_sclk),
        .serial_in(serial_in), .serial_out_pin(serial_out_pin),
        .serial_out_oe(serial_out_oe)
    );
    ast_host_model u_ast_host_model
    (
        .link_sclk(link_sclk), .serial_in(serial_in),
        .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
        .rx_word(rx_word), .rx_stb(rx_stb)
    );
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // Bus write; the answer goes to the monitor
    task automatic wr(input logic [7:0] a, input ast_word_t d,
                      input logic [1:0] r);
        q.push_back({r, 64'h0});
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid);
        bready <= 1'b0;
    endtask
    // Bus read with masked expectation
    task automatic rd(input logic [7:0] a, input ast_word_t ex,
                      input ast_word_t m, input logic [1:0] r);
        q.push_back({r, m, ex});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid);
        rready <= 1'b0;
    endtask
    // Wait for the end of a result update
    task automatic wait_fall();
        for (n = 0; n < 99 && result_ready_n !== 1'b1; n++) @(posedge aclk);
        for (n = 0; n < 99 && result_ready_n !== 1'b0; n++) @(posedge aclk);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Compare bus answers and serial words with the oldest note
    always @(posedge aclk)
    begin
        if ((rvalid && rready) || (bvalid && bready))
        begin
            e = q.pop_front();
            `CHK("resp", e[65:64], rvalid ? rresp : bresp)
            if (rvalid) `CHK("rdata", e[31:0], rdata & e[63:32])
        end
    end
    always @(posedge rx_stb)
    begin
        e = q.pop_front();
        `CHK("serial", e[23:0], rx_word)
    end
    // Main sequence
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_PERIOD, {16'h0000, PERIOD_RST}, 32'hffff_ffff, RESP_OKAY);
        rd(8'h14, 32'h0000_0000, 32'hffff_ffff, RESP_SLVERR);
        wr(ADDR_RESULT, 32'h0000_0001, RESP_SLVERR);
        wr(ADDR_PERIOD, PER, RESP_OKAY);
        repeat (8 * PER) @(posedge aclk);
        seed = xs(seed);
        x = seed[23:0];
        raw_sample <= x;
        repeat (4 * PER) @(posedge aclk);
        rd(ADDR_RESULT, {8'h00, x}, 32'h00ff_ffff, RESP_OKAY);
        wr(ADDR_CTRL, 32'h0000_0002, RESP_OKAY);
        repeat (2 * PER) @(posedge aclk);
        rd(ADDR_RESULT, {8'h00, x ^ SIGN_FLIP}, 32'h00ff_ffff, RESP_OKAY);
        raw_sample <= 24'h80_0000;
        repeat (4 * PER) @(posedge aclk);
        q.push_back(66'h0);
        u_ast_host_model.frame(8'h80, 32);
        // Sync command keeps history: next result mixes new and old input.
        // Two updates first fill both history words with a random value
        wait_fall();
        seed = xs(seed);
        raw_sample <= seed[23:0];
        wait_fall();
        wait_fall();
        s = {2'b00, seed[23:0]} * 26'h000_0003;
        wr(ADDR_CTRL, 32'h0000_0003, RESP_OKAY);
        seed = xs(seed);
        x = seed[23:0];
        raw_sample <= x;
        rd(ADDR_MODCNT, 32'h0000_0000, 32'h0000_fff8, RESP_OKAY);
        s = s + {2'b00, x};
        wait_fall();
        rd(ADDR_RESULT, {8'h00, s[25:2] ^ SIGN_FLIP}, 32'h00ff_ffff,
           RESP_OKAY);
        // Sync pin restarts the count; data-ready one period later
        wait_fall();
        sync_pulse_n <= 1'b0;
        repeat (2) @(posedge aclk);
        sync_pulse_n <= 1'b1;
        for (n = 2; n < 99 && result_ready_n !== 1'b1; n++) @(posedge aclk);
        `CHK("sync", 1'b1, n >= PER + 2 && n <= PER + 6)
        // Serial read, stall, recovery and a fresh read
        repeat (4 * PER) @(posedge aclk);
        q.push_back({2'b00, 40'h0, x ^ SIGN_FLIP});
        u_ast_host_model.frame(8'h80, 32);
        u_ast_host_model.frame(8'h80, 3);
        repeat (2 * PER) @(posedge aclk);
        rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_ff00, RESP_OKAY);
        repeat (4 * PER) @(posedge aclk);
        rd(ADDR_STATUS, 32'h0000_0100, 32'h0000_ff00, RESP_OKAY);
        rd(ADDR_PERIOD, PER, 32'hffff_ffff, RESP_OKAY);
        rd(ADDR_CTRL, 32'h0000_0002, 32'hffff_ffff, RESP_OKAY);
        q.push_back({2'b00, 40'h0, x ^ SIGN_FLIP});
        u_ast_host_model.frame(8'h80, 32);
        u_ast_host_model.frame(8'h00, 8);
        repeat (10 * PER) @(posedge aclk);
        rd(ADDR_STATUS, 32'h0000_0100, 32'h0000_ff00, RESP_OKAY);
        complete_run();
    end
    // Watchdog well beyond the sequence length
    initial
    begin
        #400000;
        err_count++;
        complete_run();
    end
endmodule
`default_nettype wire
